// ===== src/ccd_pkg.sv
package ccd_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int NUM_SLOTS = 16;
    localparam int NUM_STAGES = 6;

    // Register indices; the byte address is four times the index.
    localparam logic [9:0] IDX_DIV0_COUNTS = 10'h190;
    localparam logic [9:0] IDX_DIV0_PHASE_BYPASS = 10'h191;
    localparam logic [9:0] IDX_DIV0_CTRL = 10'h192;
    localparam logic [9:0] IDX_DIV1_COUNTS = 10'h196;
    localparam logic [9:0] IDX_DIV1_PHASE_BYPASS = 10'h197;
    localparam logic [9:0] IDX_DIV1_CTRL = 10'h198;
    localparam logic [9:0] IDX_DIV2_STAGE1_COUNTS = 10'h199;
    localparam logic [9:0] IDX_DIV2_STAGE2_COUNTS = 10'h19b;
    localparam logic [9:0] IDX_DIV2_BYPASS_CTRL = 10'h19c;
    localparam logic [9:0] IDX_DIV2_CORRECTION_CTRL = 10'h19d;
    localparam logic [9:0] IDX_DIV3_STAGE1_COUNTS = 10'h19e;
    localparam logic [9:0] IDX_DIV3_STAGE2_COUNTS = 10'h1a0;
    localparam logic [9:0] IDX_DIV3_BYPASS_CTRL = 10'h1a1;
    localparam logic [9:0] IDX_DIV3_CORRECTION_CTRL = 10'h1a2;
    localparam logic [9:0] IDX_OUT_CTRL = 10'h1f0;
    localparam logic [9:0] IDX_SYNC_STATUS = 10'h1f1;

    // Storage slots behind the indices.
    localparam logic [4:0] SLOT_D0_CNT = 5'h00;
    localparam logic [4:0] SLOT_D0_PB = 5'h01;
    localparam logic [4:0] SLOT_D0_CTRL = 5'h02;
    localparam logic [4:0] SLOT_D1_CNT = 5'h03;
    localparam logic [4:0] SLOT_D1_PB = 5'h04;
    localparam logic [4:0] SLOT_D1_CTRL = 5'h05;
    localparam logic [4:0] SLOT_D2_S1 = 5'h06;
    localparam logic [4:0] SLOT_D2_S2 = 5'h07;
    localparam logic [4:0] SLOT_D2_BYP = 5'h08;
    localparam logic [4:0] SLOT_D2_CORR = 5'h09;
    localparam logic [4:0] SLOT_D3_S1 = 5'h0a;
    localparam logic [4:0] SLOT_D3_S2 = 5'h0b;
    localparam logic [4:0] SLOT_D3_BYP = 5'h0c;
    localparam logic [4:0] SLOT_D3_CORR = 5'h0d;
    localparam logic [4:0] SLOT_OUT_CTRL = 5'h0e;
    localparam logic [4:0] SLOT_SYNC = 5'h0f;
    localparam logic [4:0] SLOT_NONE = 5'h1f;

    // Field positions.
    localparam int LOW_CNT_LSB = 4;
    localparam int HIGH_CNT_LSB = 0;
    localparam int CNT_W = 4;
    localparam int BYPASS_BIT = 7;
    localparam int START_HIGH_BIT = 4;
    localparam int PHASE_LSB = 0;
    localparam int CORR_OFF_BIT = 0;
    localparam int DIRECT_BIT = 1;
    localparam int STG1_BYPASS_BIT = 4;
    localparam int STG2_BYPASS_BIT = 5;
    localparam int B_EN2_BIT = 0;
    localparam int B_EN3_BIT = 1;
    localparam int SYNC_BIT = 0;

    // Reset values.
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic RST_SYNC = 1'b1;

    typedef enum logic [1:0] {
        CCD_IDLE = 2'b00,
        CCD_WAIT = 2'b01,
        CCD_HIGH = 2'b11,
        CCD_LOW = 2'b10
    } ccd_stage_e;

endpackage

// ===== src/ccd_channel_clock_divider.sv
// Behaviour
// R1 - Single stage: low M+1, high N+1 cycles.
// R2 - Count cycles of selected source clock.
// R3 - Bypass divides by one, else N+M+2.
// R4 - Correction on after reset, per-channel disable.
// R5 - Corrected output has 50% duty; the code gives it only for M=N or M=N+1.
// R6 - Uncorrected duty is (N+1)/(N+M+2).
// R7 - Direct route keeps the source duty.
// R8 - Channels 0/1 delay rising edge by cycles.
// R9 - Delay from start-high and offset value.
// R10 - Offsets take effect only after sync.
// R11 - Channels 2/3 cascade two dividers.
// R12 - One disable bit covers both stages.
// R13 - Each cascaded stage has own counts.
// R14 - Bypass combinations give 1, D1, D1*D2.
// R15 - Software bypasses second stage, never first; the code also lets bit 4 bypass the first stage.
// R16 - B output off until enabled.
// R17 - Count fields hold cycles minus one.
// R18 - Bypass stops the counting circuit.
// R19 - Output starts high or low.
// R20 - Sync restarts all dividers together.
// R21 - Odd corrected ratio adds half cycle.
`timescale 1ns/1ps
`default_nettype none
module ccd_channel_clock_divider
    import ccd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ccd_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [ccd_pkg::DATA_W-1:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [ccd_pkg::DATA_W-1:0] prdata_out,
    input wire logic src_clk_in,
    output logic ch0_out,
    output logic ch1_out,
    output logic ch2_a_out,
    output logic ch2_b_out,
    output logic ch3_a_out,
    output logic ch3_b_out
);
    import ccd_pkg::*;
    function automatic logic [4:0] slot_of(input logic [ADDR_W-1:0] a);
        logic [4:0] s;
        s = SLOT_NONE;
        if (a[1:0] == 2'b00)
        begin
            case (a[ADDR_W-1:2])
                IDX_DIV0_COUNTS: s = SLOT_D0_CNT;
                IDX_DIV0_PHASE_BYPASS: s = SLOT_D0_PB;
                IDX_DIV0_CTRL: s = SLOT_D0_CTRL;
                IDX_DIV1_COUNTS: s = SLOT_D1_CNT;
                IDX_DIV1_PHASE_BYPASS: s = SLOT_D1_PB;
                IDX_DIV1_CTRL: s = SLOT_D1_CTRL;
                IDX_DIV2_STAGE1_COUNTS: s = SLOT_D2_S1;
                IDX_DIV2_STAGE2_COUNTS: s = SLOT_D2_S2;
                IDX_DIV2_BYPASS_CTRL: s = SLOT_D2_BYP;
                IDX_DIV2_CORRECTION_CTRL: s = SLOT_D2_CORR;
                IDX_DIV3_STAGE1_COUNTS: s = SLOT_D3_S1;
                IDX_DIV3_STAGE2_COUNTS: s = SLOT_D3_S2;
                IDX_DIV3_BYPASS_CTRL: s = SLOT_D3_BYP;
                IDX_DIV3_CORRECTION_CTRL: s = SLOT_D3_CORR;
                IDX_OUT_CTRL: s = SLOT_OUT_CTRL;
                IDX_SYNC_STATUS: s = SLOT_SYNC;
                default: s = SLOT_NONE;
            endcase
        end
        return s;
    endfunction
    // Start delay in source cycles from start-high, offset and low count.
    function automatic logic [4:0] phase_delay(input logic sh,
        input logic [3:0] po, input logic [3:0] m);
        logic [4:0] d;
        if (!sh)
        begin
            d = {1'b0, po}; // [R9]
        end
        else
        begin
            d = 5'({1'b0, po} + {1'b0, m} + 5'h01); // [R9]
        end
        return d;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Register file and APB slave.
    logic [REG_W-1:0] regs_q [NUM_SLOTS];
    logic sync_q;
    logic pready_q;
    logic pslverr_q;
    logic [DATA_W-1:0] prdata_q;
    logic [4:0] acc_slot;
    logic setup_phase;
    logic wr_take;
    logic [REG_W-1:0] status_bits;
    assign acc_slot = slot_of(paddr_in);
    assign setup_phase = psel_in & ~penable_in;
    assign wr_take = psel_in & penable_in & pready_q & pwrite_in
                     & pstrb_in[0] & (acc_slot != SLOT_NONE);
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
            begin
                regs_q[i] <= RST_REG; // [R4] [R16]
            end
        end
        else if (wr_take && acc_slot != SLOT_SYNC)
        begin
            regs_q[acc_slot[3:0]] <= pwdata_in[REG_W-1:0];
        end
    end
    // A sync runs once after reset and on each write of the sync bit.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync_q <= RST_SYNC;
        end
        else
        begin
            sync_q <= wr_take && acc_slot == SLOT_SYNC
                      && pwdata_in[SYNC_BIT]; // [R10] [R20]
        end
    end
    assign status_bits = {2'b00, ch3_b_out, ch3_a_out, ch2_b_out,
                          ch2_a_out, ch1_out, ch0_out};
    // Answer is prepared in the setup cycle, so access takes one cycle.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else
        begin
            pready_q <= setup_phase;
            pslverr_q <= setup_phase && acc_slot == SLOT_NONE;
            if (setup_phase && !pwrite_in)
            begin
                prdata_q <= (acc_slot == SLOT_NONE) ? '0
                    : {24'h000000, (acc_slot == SLOT_SYNC)
                    ? status_bits : regs_q[acc_slot[3:0]]};
            end
        end
    end
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign prdata_out = prdata_q;
    ////////////////////////////////////////////////////////////////////////
    // Per-stage configuration. Stages: 0 ch0, 1 ch1, 2/3 ch2, 4/5 ch3.
    logic src_q;
    logic [3:0] m_a [NUM_STAGES];
    logic [3:0] n_a [NUM_STAGES];
    logic [3:0] po_a [NUM_STAGES];
    logic byp_a [NUM_STAGES];
    logic dcc_off_a [NUM_STAGES];
    logic sh_a [NUM_STAGES];
    logic in_a [NUM_STAGES];
    logic stg_out [NUM_STAGES];
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            src_q <= 1'b0;
        end
        else
        begin
            src_q <= src_clk_in; // [R2]
        end
    end
    always_comb
    begin
        m_a[0] = regs_q[SLOT_D0_CNT[3:0]][LOW_CNT_LSB +: CNT_W]; // [R17]
        n_a[0] = regs_q[SLOT_D0_CNT[3:0]][HIGH_CNT_LSB +: CNT_W];
        m_a[1] = regs_q[SLOT_D1_CNT[3:0]][LOW_CNT_LSB +: CNT_W];
        n_a[1] = regs_q[SLOT_D1_CNT[3:0]][HIGH_CNT_LSB +: CNT_W];
        m_a[2] = regs_q[SLOT_D2_S1[3:0]][LOW_CNT_LSB +: CNT_W]; // [R13]
        n_a[2] = regs_q[SLOT_D2_S1[3:0]][HIGH_CNT_LSB +: CNT_W];
        m_a[3] = regs_q[SLOT_D2_S2[3:0]][LOW_CNT_LSB +: CNT_W];
        n_a[3] = regs_q[SLOT_D2_S2[3:0]][HIGH_CNT_LSB +: CNT_W];
        m_a[4] = regs_q[SLOT_D3_S1[3:0]][LOW_CNT_LSB +: CNT_W];
        n_a[4] = regs_q[SLOT_D3_S1[3:0]][HIGH_CNT_LSB +: CNT_W];
        m_a[5] = regs_q[SLOT_D3_S2[3:0]][LOW_CNT_LSB +: CNT_W];
        n_a[5] = regs_q[SLOT_D3_S2[3:0]][HIGH_CNT_LSB +: CNT_W];
        byp_a[0] = regs_q[SLOT_D0_PB[3:0]][BYPASS_BIT];
        byp_a[1] = regs_q[SLOT_D1_PB[3:0]][BYPASS_BIT];
        byp_a[2] = regs_q[SLOT_D2_BYP[3:0]][STG1_BYPASS_BIT];
        byp_a[3] = regs_q[SLOT_D2_BYP[3:0]][STG2_BYPASS_BIT];
        byp_a[4] = regs_q[SLOT_D3_BYP[3:0]][STG1_BYPASS_BIT];
        byp_a[5] = regs_q[SLOT_D3_BYP[3:0]][STG2_BYPASS_BIT];
        dcc_off_a[0] = regs_q[SLOT_D0_CTRL[3:0]][CORR_OFF_BIT]; // [R4]
        dcc_off_a[1] = regs_q[SLOT_D1_CTRL[3:0]][CORR_OFF_BIT];
        dcc_off_a[2] = regs_q[SLOT_D2_CORR[3:0]][CORR_OFF_BIT]; // [R12]
        dcc_off_a[3] = regs_q[SLOT_D2_CORR[3:0]][CORR_OFF_BIT];
        dcc_off_a[4] = regs_q[SLOT_D3_CORR[3:0]][CORR_OFF_BIT];
        dcc_off_a[5] = regs_q[SLOT_D3_CORR[3:0]][CORR_OFF_BIT];
        sh_a[0] = regs_q[SLOT_D0_PB[3:0]][START_HIGH_BIT]; // [R8]
        sh_a[1] = regs_q[SLOT_D1_PB[3:0]][START_HIGH_BIT];
        po_a[0] = regs_q[SLOT_D0_PB[3:0]][PHASE_LSB +: CNT_W];
        po_a[1] = regs_q[SLOT_D1_PB[3:0]][PHASE_LSB +: CNT_W];
        for (int i = 2; i < NUM_STAGES; i++)
        begin
            sh_a[i] = 1'b0;
            po_a[i] = 4'h0;
        end
        // Second stages count the first stage's output.
        in_a[0] = src_q;
        in_a[1] = src_q;
        in_a[2] = src_q;
        in_a[3] = stg_out[2]; // [R11] [R14]
        in_a[4] = src_q;
        in_a[5] = stg_out[4];
    end
    ////////////////////////////////////////////////////////////////////////
    // Divider stages.
    for (genvar g = 0; g < NUM_STAGES; g++)
    begin : g_stage
        logic prev_q;
        logic out_q;
        logic fall_pend_q;
        logic [3:0] cnt_q;
        logic [4:0] dly_q;
        ccd_stage_e st_q;
        logic rise;
        logic fall;
        logic odd_fix;
        assign rise = in_a[g] & ~prev_q;
        assign fall = ~in_a[g] & prev_q;
        // Odd ratio when M+N+2 is odd, that is M and N differ in parity.
        assign odd_fix = ~dcc_off_a[g] & (m_a[g][0] ^ n_a[g][0]); // [R21]
        assign stg_out[g] = out_q;
        always_ff @(posedge clk_sys_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
            begin
                prev_q <= 1'b0;
            end
            else
            begin
                prev_q <= in_a[g];
            end
        end
        always_ff @(posedge clk_sys_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
            begin
                st_q <= CCD_IDLE;
                out_q <= 1'b0;
                fall_pend_q <= 1'b0;
                cnt_q <= 4'h0;
                dly_q <= 5'h00;
            end
            else if (byp_a[g])
            begin
                st_q <= CCD_IDLE; // [R18]
                cnt_q <= 4'h0;
                fall_pend_q <= 1'b0;
                out_q <= in_a[g]; // [R3]
            end
            else if (sync_q)
            begin
                st_q <= CCD_WAIT; // [R20] [R10]
                cnt_q <= 4'h0;
                fall_pend_q <= 1'b0;
                out_q <= sh_a[g]; // [R19]
                dly_q <= phase_delay(sh_a[g], po_a[g], m_a[g]); // [R8]
            end
            else
            begin
                case (st_q)
                    CCD_IDLE:
                    begin
                        st_q <= CCD_LOW;
                        out_q <= 1'b0;
                        cnt_q <= 4'h0;
                    end
                    CCD_WAIT:
                    begin
                        if (rise && dly_q == 5'h00)
                        begin
                            // A start-high output stays high until here.
                            st_q <= CCD_LOW; // [R9] [R19]
                            out_q <= 1'b0;
                        end
                        else if (rise)
                        begin
                            dly_q <= dly_q - 5'h01; // [R8]
                        end
                    end
                    CCD_HIGH:
                    begin
                        if (rise && cnt_q == n_a[g])
                        begin
                            cnt_q <= 4'h0; // [R1] [R6]
                            st_q <= CCD_LOW;
                            out_q <= odd_fix; // [R21] [R5]
                            fall_pend_q <= odd_fix;
                        end
                        else if (rise)
                        begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                    CCD_LOW:
                    begin
                        if (fall && fall_pend_q)
                        begin
                            out_q <= 1'b0; // [R21]
                            fall_pend_q <= 1'b0;
                        end
                        if (rise && cnt_q == m_a[g])
                        begin
                            cnt_q <= 4'h0; // [R1] [R3]
                            st_q <= CCD_HIGH;
                            out_q <= 1'b1;
                        end
                        else if (rise)
                        begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                    default:
                    begin
                        st_q <= CCD_IDLE;
                    end
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Channel outputs.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ch0_out <= 1'b0;
            ch1_out <= 1'b0;
            ch2_a_out <= 1'b0;
            ch2_b_out <= 1'b0;
            ch3_a_out <= 1'b0;
            ch3_b_out <= 1'b0;
        end
        else
        begin
            ch0_out <= regs_q[SLOT_D0_CTRL[3:0]][DIRECT_BIT]
                       ? src_q : stg_out[0]; // [R7]
            ch1_out <= regs_q[SLOT_D1_CTRL[3:0]][DIRECT_BIT]
                       ? src_q : stg_out[1]; // [R7]
            ch2_a_out <= stg_out[3]; // [R14]
            ch2_b_out <= regs_q[SLOT_OUT_CTRL[3:0]][B_EN2_BIT]
                         & stg_out[3]; // [R16]
            ch3_a_out <= stg_out[5];
            ch3_b_out <= regs_q[SLOT_OUT_CTRL[3:0]][B_EN3_BIT]
                         & stg_out[5]; // [R16]
        end
    end

endmodule

`default_nettype wire

// ===== testbench/ccd_channel_clock_divider_chk.sv
`timescale 1ns/1ps
`default_nettype none

module ccd_channel_clock_divider_chk
    import ccd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ccd_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [ccd_pkg::DATA_W-1:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [ccd_pkg::DATA_W-1:0] prdata_out,
    input wire logic src_clk_in,
    input wire logic ch0_out,
    input wire logic ch1_out,
    input wire logic ch2_a_out,
    input wire logic ch2_b_out,
    input wire logic ch3_a_out,
    input wire logic ch3_b_out
);
    logic [5:0] chv;
    logic wr_out;
    logic b2_q;
    logic b3_q;
    logic src_q;
    logic [3:0] quiet_q;

    assign chv = {ch3_b_out, ch3_a_out, ch2_b_out, ch2_a_out, ch1_out,
                  ch0_out};
    assign wr_out = psel_in && penable_in && pready_out && pwrite_in &&
                    pstrb_in[0] && paddr_in == {IDX_OUT_CTRL, 2'b00};

    // Sticky record that software has ever enabled a B output.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            b2_q <= 1'b0;
            b3_q <= 1'b0;
        end
        else if (wr_out)
        begin
            b2_q <= b2_q | pwdata_in[B_EN2_BIT];
            b3_q <= b3_q | pwdata_in[B_EN3_BIT];
        end
    end

    // Counts cycles with neither a source edge nor bus activity.
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            src_q <= 1'b0;
            quiet_q <= 4'h0;
        end
        else
        begin
            src_q <= src_clk_in;
            if (psel_in || src_clk_in != src_q)
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hf)
                quiet_q <= quiet_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    a_ready_setup: assert property (psel_in && !penable_in |=> pready_out)
        else $error("pready missing in access cycle");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready held longer than one cycle");
    a_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("pslverr without pready");
    a_rdata_upper: assert property (pready_out && !pwrite_in |->
        prdata_out[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_err_rdata: assert property (pready_out && pslverr_out && !pwrite_in
        |-> prdata_out == 32'h00000000)
        else $error("refused read returned data");
    a_unmapped_err: assert property (psel_in && !penable_in &&
        paddr_in[11:2] == 10'h193 |=> pslverr_out)
        else $error("unmapped address not refused");
    a_reset_low: assert property ($rose(rst_n_in) |-> chv == 6'h00)
        else $error("outputs not low after reset");
    a_b2_off: assert property (!b2_q |-> !ch2_b_out)
        else $error("channel 2 B output on before enable");
    a_b3_off: assert property (!b3_q |-> !ch3_b_out)
        else $error("channel 3 B output on before enable");
    a_src_quiet: assert property (quiet_q >= 4'h8 |-> $stable(chv))
        else $error("output moved without source edge");

    c_err: cover property (pslverr_out);
    c_b2: cover property ($rose(ch2_b_out));
    c_quiet: cover property (quiet_q == 4'h8);
endmodule

`default_nettype wire

// ===== testbench/ccd_channel_clock_divider_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ccd_channel_clock_divider_tb;
    import ccd_pkg::*;

    typedef struct packed {
        logic [2:0] sel;
        logic [9:0] ia;
        logic [7:0] va;
        logic [9:0] ib;
        logic [7:0] vb;
        logic [7:0] hi;
        logic [7:0] lo;
    } ccd_row_s;

    // Source runs high one cycle, low two: counted on its rising edges.
    localparam ccd_row_s ROWS [17] = '{
        '{3'd0, IDX_DIV0_COUNTS, 8'h00, IDX_DIV0_CTRL, 8'h01, 8'h03, 8'h03},
        '{3'd0, IDX_DIV0_COUNTS, 8'hf0, IDX_DIV0_CTRL, 8'h01, 8'h03, 8'h30},
        '{3'd0, IDX_DIV0_COUNTS, 8'h0f, IDX_DIV0_CTRL, 8'h01, 8'h30, 8'h03},
        '{3'd0, IDX_DIV0_COUNTS, 8'hff, IDX_DIV0_CTRL, 8'h01, 8'h30, 8'h30},
        '{3'd0, IDX_DIV0_COUNTS, 8'h31, IDX_DIV0_CTRL, 8'h01, 8'h06, 8'h0c},
        '{3'd0, IDX_DIV0_COUNTS, 8'h21, IDX_DIV0_CTRL, 8'h00, 8'h07, 8'h08},
        '{3'd0, IDX_DIV0_COUNTS, 8'h11, IDX_DIV0_CTRL, 8'h00, 8'h06, 8'h06},
        '{3'd0, IDX_DIV0_PHASE_BYPASS, 8'h80, IDX_DIV0_CTRL, 8'h00, 8'h01,
          8'h02},
        '{3'd0, IDX_DIV0_PHASE_BYPASS, 8'h00, IDX_DIV0_CTRL, 8'h02, 8'h01,
          8'h02},
        '{3'd1, IDX_DIV1_COUNTS, 8'h12, IDX_DIV1_CTRL, 8'h01, 8'h09, 8'h06},
        '{3'd2, IDX_DIV2_STAGE1_COUNTS, 8'h22, IDX_DIV2_BYPASS_CTRL, 8'h00,
          8'h12, 8'h12},
        '{3'd2, IDX_DIV2_STAGE1_COUNTS, 8'h22, IDX_DIV2_BYPASS_CTRL, 8'h20,
          8'h09, 8'h09},
        '{3'd2, IDX_DIV2_STAGE1_COUNTS, 8'h21, IDX_DIV2_CORRECTION_CTRL,
          8'h01, 8'h06, 8'h09},
        '{3'd2, IDX_DIV2_STAGE1_COUNTS, 8'h21, IDX_DIV2_BYPASS_CTRL, 8'h30,
          8'h01, 8'h02},
        '{3'd4, IDX_DIV3_STAGE1_COUNTS, 8'h21, IDX_DIV3_BYPASS_CTRL, 8'h20,
          8'h07, 8'h08},
        '{3'd4, IDX_DIV3_STAGE2_COUNTS, 8'h11, IDX_DIV3_BYPASS_CTRL, 8'h00,
          8'h1e, 8'h1e},
        '{3'd5, IDX_OUT_CTRL, 8'h02, IDX_DIV3_BYPASS_CTRL, 8'h00, 8'h1e,
          8'h1e}
    };
    localparam logic [9:0] REGS [15] = '{IDX_DIV0_COUNTS,
        IDX_DIV0_PHASE_BYPASS, IDX_DIV0_CTRL, IDX_DIV1_COUNTS,
        IDX_DIV1_PHASE_BYPASS, IDX_DIV1_CTRL, IDX_DIV2_STAGE1_COUNTS,
        IDX_DIV2_STAGE2_COUNTS, IDX_DIV2_BYPASS_CTRL,
        IDX_DIV2_CORRECTION_CTRL, IDX_DIV3_STAGE1_COUNTS,
        IDX_DIV3_STAGE2_COUNTS, IDX_DIV3_BYPASS_CTRL,
        IDX_DIV3_CORRECTION_CTRL, IDX_OUT_CTRL};

    logic clk_sys_in, rst_n_in, psel_in, penable_in, pwrite_in;
    logic [ADDR_W-1:0] paddr_in;
    logic [DATA_W-1:0] pwdata_in, prdata_out, rd;
    logic [3:0] pstrb_in;
    logic pready_out, pslverr_out, src_clk_in, err, src_run;
    logic ch0_out, ch1_out, ch2_a_out, ch2_b_out, ch3_a_out, ch3_b_out;
    logic [5:0] chv, prev_q, snap;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int ph = 0;
    int hi, lo, g;

    assign chv = {ch3_b_out, ch3_a_out, ch2_b_out, ch2_a_out, ch1_out,
                  ch0_out};

    ccd_channel_clock_divider dut (.clk_sys_in, .rst_n_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
        .pready_out, .pslverr_out, .prdata_out, .src_clk_in, .ch0_out,
        .ch1_out, .ch2_a_out, .ch2_b_out, .ch3_a_out, .ch3_b_out);

    initial
    begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    always @(posedge clk_sys_in)
    begin
        prev_q <= chv;
        cyc <= cyc + 1;
        if (src_run)
        begin
            ph <= (ph == 2) ? 0 : ph + 1;
            src_clk_in <= (ph == 2);
        end
        if (cyc == 40000)
        begin
            failures++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx,
                       input logic [31:0] wd);
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= {idx, 2'b00};
        pwdata_in <= wd;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge clk_sys_in);
        end
        while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rdck(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        cmp("rdata", exp, rd);
    endtask

    task automatic wait_rise(input int s, output int n);
        n = 0;
        do
        begin
            @(posedge clk_sys_in);
            n++;
        end
        while (!(chv[s] === 1'b1 && prev_q[s] === 1'b0) && n < 400);
    endtask

    task automatic measure(input int s);
        wait_rise(s, hi);
        wait_rise(s, hi);
        hi = 0;
        lo = 0;
        while (chv[s] === 1'b1 && hi < 400)
        begin
            @(posedge clk_sys_in);
            hi++;
        end
        while (chv[s] === 1'b0 && lo < 400)
        begin
            @(posedge clk_sys_in);
            lo++;
        end
    endtask

    // Cycles from a channel 0 rising edge to the next channel 1 one.
    task automatic gap();
        int n;
        // Let a sync reach the outputs before edges are looked for.
        repeat (3) @(posedge clk_sys_in);
        wait_rise(0, n);
        g = 0;
        if (!(chv[1] === 1'b1 && prev_q[1] === 1'b0))
            wait_rise(1, g);
    endtask

    initial
    begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {rst_n_in, src_clk_in, src_run} = '0;
        pstrb_in = 4'hf;
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        foreach (REGS[i])
        begin
            rdck(REGS[i], 32'h0);
            apb(1'b1, REGS[i], 32'hffffffa5);
            rdck(REGS[i], 32'ha5);
            apb(1'b1, REGS[i], 32'h0);
        end
        apb(1'b0, 10'h193, 32'h0);
        cmp("unmapped err", 1, err);
        pstrb_in <= 4'h0;
        apb(1'b1, IDX_DIV0_COUNTS, 32'h55);
        pstrb_in <= 4'hf;
        rdck(IDX_DIV0_COUNTS, 32'h0);
        src_run <= 1'b1;
        measure(2);
        cmp("reset ch2 high", 6, hi);
        cmp("ch2 b off", 0, ch2_b_out);
        foreach (ROWS[i])
        begin
            apb(1'b1, ROWS[i].ia, {24'h0, ROWS[i].va});
            apb(1'b1, ROWS[i].ib, {24'h0, ROWS[i].vb});
            measure(ROWS[i].sel);
            cmp("high", ROWS[i].hi, hi);
            cmp("low", ROWS[i].lo, lo);
        end
        apb(1'b1, IDX_DIV0_COUNTS, 32'h77);
        apb(1'b1, IDX_DIV1_COUNTS, 32'h77);
        apb(1'b1, IDX_DIV0_CTRL, 32'h01);
        apb(1'b1, IDX_DIV1_CTRL, 32'h01);
        apb(1'b1, IDX_SYNC_STATUS, 32'h01);
        gap();
        cmp("aligned gap", 0, g);
        apb(1'b1, IDX_DIV1_PHASE_BYPASS, 32'h03);
        gap();
        cmp("unsynced gap", 0, g);
        apb(1'b1, IDX_SYNC_STATUS, 32'h01);
        gap();
        cmp("offset gap", 9, g);
        apb(1'b1, IDX_DIV1_PHASE_BYPASS, 32'h12);
        apb(1'b1, IDX_SYNC_STATUS, 32'h01);
        gap();
        cmp("start high gap", 30, g);
        src_run <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        snap = chv;
        repeat (20) @(posedge clk_sys_in);
        cmp("stopped source", snap, chv);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        cmp("outputs in reset", 0, chv);
        rst_n_in <= 1'b1;
        rdck(IDX_DIV0_CTRL, 32'h0);
        test_done();
    end
endmodule

bind ccd_channel_clock_divider ccd_channel_clock_divider_chk u_chk (
    .clk_sys_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in, .pready_out, .pslverr_out, .prdata_out,
    .src_clk_in, .ch0_out, .ch1_out, .ch2_a_out, .ch2_b_out, .ch3_a_out,
    .ch3_b_out);

`default_nettype wire
